// [hw/bus_ctl_pkg.sv]
/*
 * Shared constants, types and helpers of the bus controller command interpreter:
 * register offsets and fields, reset values, timing counts, ASCII and bus message bytes.
 * Assumes a 100 MHz system clock; every user compiles this package first.
 */
package bus_ctl_pkg;

	// register byte offsets on the wishbone slave
	localparam logic [7:0] REG_CTRL = 8'h00;
	localparam logic [7:0] REG_STATUS = 8'h04;
	localparam logic [7:0] REG_SENT = 8'h08;
	localparam logic [7:0] REG_ADDR = 8'h0C;
	localparam logic [7:0] REG_TMO = 8'h10;
	// control register fields and reset
	localparam int CTRL_SYSCTL_BIT = 0;
	localparam int CTRL_SPIGN_BIT = 1;
	localparam logic CTRL_SYSCTL_RESET = 1'b1;
	localparam logic CTRL_SPIGN_RESET = 1'b0;
	// status register fields
	localparam int STAT_CTL_LSB = 0;
	localparam int STAT_CIC_BIT = 2;
	localparam int STAT_NOT_IN_CHARGE_BIT = 4;
	localparam int STAT_IO_TIMEOUT_BIT = 5;
	localparam int STAT_NO_LISTENER_BIT = 6;
	localparam int STAT_SERIAL_BIT = 7;
	// own bus address register fields and reset
	localparam int ADDR_PAD_LSB = 0;
	localparam int ADDR_SAD_LSB = 8;
	localparam int ADDR_SAD_EN_BIT = 15;
	localparam logic [4:0] PAD_RESET = 5'h00;
	localparam logic SAD_EN_RESET = 1'b0;
	// timing
	localparam int CLK_MHZ = 100;
	localparam int IFC_TIME_US = 100;
	localparam int IFC_CYCLES = IFC_TIME_US * CLK_MHZ;
	localparam int IO_TIMEOUT_S = 10;
	localparam int IO_TIMEOUT_CYCLES = IO_TIMEOUT_S * CLK_MHZ * 1000000;
	localparam int KEY_MAX = 5;
	// ascii characters
	localparam logic [7:0] CH_CR = 8'h0D;
	localparam logic [7:0] CH_LF = 8'h0A;
	localparam logic [7:0] CH_SP = 8'h20;
	localparam logic [7:0] CH_COMMA = 8'h2C;
	localparam logic [7:0] CH_PLUS = 8'h2B;
	localparam logic [7:0] CH_HASH = 8'h23;
	localparam logic [7:0] CH_ZERO = 8'h30;
	localparam logic [7:0] CH_NINE = 8'h39;
	// interface message bytes
	localparam logic [7:0] MSG_DCL = 8'h14;
	localparam logic [7:0] MSG_SDC = 8'h04;
	localparam logic [7:0] MSG_UNL = 8'h3F;
	localparam logic [7:0] MSG_LAD = 8'h20;
	localparam logic [7:0] MSG_SAD = 8'h60;
	// command keywords, lower case
	localparam logic [39:0] KW_CAC = 40'h0000636163;
	localparam logic [39:0] KW_CADDR = 40'h6361646472;
	localparam logic [39:0] KW_CLR = 40'h0000636C72;
	localparam logic [39:0] KW_CMD = 40'h0000636D64;

	typedef enum logic [1:0] {CTL_IDLE, CTL_STANDBY, CTL_ACTIVE} ctl_state_t;
	typedef enum logic [2:0] {K_NONE, K_CAC, K_CADDR, K_CLR, K_CMD} kw_t;
	typedef enum logic [1:0] {CHK_OK, CHK_IFC, CHK_ERR} chk_t;

	// fold an ascii letter to lower case
	function automatic logic [7:0] to_lower(input logic [7:0] c);
		to_lower = (c >= 8'h41 && c <= 8'h5A) ? (c | 8'h20) : c;
	endfunction : to_lower

	// map a collected keyword to a command code
	function automatic kw_t decode_kw(input logic [39:0] key, input logic [2:0] len);
		decode_kw = K_NONE;
		if (len == 3'h3 && key == KW_CAC)
			decode_kw = K_CAC;
		else if (len == 3'h5 && key == KW_CADDR)
			decode_kw = K_CADDR;
		else if (len == 3'h3 && key == KW_CLR)
			decode_kw = K_CLR;
		else if (len == 3'h3 && key == KW_CMD)
			decode_kw = K_CMD;
	endfunction : decode_kw

	// decide whether an operation needing controller capability may go ahead
	function automatic chk_t ctl_check(input logic cic, input logic passed, input logic sysctl);
		if (cic)
			ctl_check = CHK_OK;
		else if (!passed && sysctl)
			ctl_check = CHK_IFC;
		else
			ctl_check = CHK_ERR;
	endfunction : ctl_check

	// merge a wishbone write into a word under its byte selects
	function automatic logic [31:0] wb_merge(input logic [31:0] old, input logic [31:0] nw,
		input logic [3:0] sel);
		for (int i = 0; i < 4; i++)
			wb_merge[i*8 +: 8] = sel[i] ? nw[i*8 +: 8] : old[i*8 +: 8];
	endfunction : wb_merge

endpackage : bus_ctl_pkg

// [hw/decimal_accumulator.sv]
/*
 * Accumulates a decimal number one ascii digit at a time.
 * Assumes digits arrive as values 0..9 on the same clock as the parser.
 */
`timescale 1ns/10ps
module decimal_accumulator #(
	parameter int WIDTH = 32
) (
	input wire logic clk,
	input wire logic sys_rst,
	input wire logic clear,
	input wire logic digit_valid,
	input wire logic [3:0] digit,
	output logic [WIDTH-1:0] value
);
	typedef struct packed {
		logic [WIDTH-1:0] acc;
	} acc_state_t;

	acc_state_t s;
	acc_state_t next_s;

	// value = value * 10 + digit, cut to width on purpose
	always_comb
	begin
		next_s = s;
		if (clear)
			next_s.acc = '0;
		else if (digit_valid)
			next_s.acc = WIDTH'((s.acc << 3) + (s.acc << 1) + WIDTH'(digit));
	end

	always_ff @(posedge clk)
	begin
		if (sys_rst)
			s <= '0;
		else
			s <= next_s;
	end

	assign value = s.acc;
endmodule : decimal_accumulator

// [hw/reply_formatter.sv]
/*
 * Formats a reply line "a[+b]<CR><LF>" with decimal values 0..31 and streams it out.
 * Assumes a byte sink with valid/ready on the same clock.
 */
`timescale 1ns/10ps
module reply_formatter (
	input wire logic clk,
	input wire logic sys_rst,
	input wire logic start,
	input wire logic [4:0] val_a,
	input wire logic has_b,
	input wire logic [4:0] val_b,
	output logic [7:0] tx_data,
	output logic tx_valid,
	input wire logic tx_ready,
	output logic busy
);
	typedef struct packed {
		logic [55:0] line;
		logic [2:0] left;
		logic busy;
	} fmt_state_t;

	fmt_state_t s;
	fmt_state_t next_s;

	// two ascii digits of a value below 32
	function automatic logic [15:0] digits(input logic [4:0] v);
		logic [4:0] t;
		t = (v >= 5'd30) ? 5'd3 : (v >= 5'd20) ? 5'd2 : (v >= 5'd10) ? 5'd1 : 5'd0;
		digits = {bus_ctl_pkg::CH_ZERO | {3'h0, t}, bus_ctl_pkg::CH_ZERO |
			{3'h0, 5'(v - 5'(t * 5'd10))}};
	endfunction : digits

	// build the line on start, shift out one byte per accepted transfer
	always_comb
	begin
		logic [15:0] da;
		logic [15:0] db;
		logic [55:0] body;
		logic [2:0] len;
		da = digits(val_a);
		db = digits(val_b);
		body = '0;
		len = '0;
		next_s = s;
		if (start && !s.busy)
		begin
			if (has_b)
			begin
				body = {da, bus_ctl_pkg::CH_PLUS, db, bus_ctl_pkg::CH_CR, bus_ctl_pkg::CH_LF};
				len = 3'd7;
			end
			else
			begin
				body = {da, bus_ctl_pkg::CH_CR, bus_ctl_pkg::CH_LF, 24'h000000};
				len = 3'd4;
			end
			if (da[15:8] == bus_ctl_pkg::CH_ZERO)
			begin
				body = {body[47:0], 8'h00}; // no leading zero
				len = 3'(len - 3'd1);
			end
			next_s.line = body;
			next_s.left = len;
			next_s.busy = 1'b1;
		end
		else if (s.busy && tx_ready)
		begin
			next_s.line = {s.line[47:0], 8'h00};
			next_s.left = 3'(s.left - 3'd1);
			next_s.busy = (s.left != 3'd1);
		end
	end

	always_ff @(posedge clk)
	begin
		if (sys_rst)
			s <= '0;
		else
			s <= next_s;
	end

	assign tx_data = s.line[55:48];
	assign tx_valid = s.busy;
	assign busy = s.busy;
endmodule : reply_formatter

// [hw/bus_controller_command_ops.sv]
/*
 * Command interpreter for four serial text commands that drive an instrument bus as
 * its controller: become active controller, set own bus address, device clear and
 * raw interface message send. Software reaches settings and status over wishbone.
 * Assumes the serial receiver, transmitter and bus handshake engine run on clk.
 */
// Design decisions made here: the register addresses and the Wishbone slave port.
// Function
// RULE1: cac 0 takes control at once; cac 1 waits for the running handshake.
// RULE2: cac without argument replies 1 when active controller, else 0.
// RULE3: cac with argument while not in charge flags not_in_charge_error, no takeover.
// RULE4: after reset the controller state is idle.
// RULE5: address argument is decimal primary, optional plus and decimal secondary.
// RULE6: a primary address alone disables secondary addressing.
// RULE7: caddr without argument replies the current bus address.
// RULE8: address holds until caddr again, reinitialise, or power loss.
// RULE9: reset address is primary 0 with secondary addressing off.
// RULE10: clr with list sends selected clear to those; without, universal clear.
// RULE11: first controller operation pulses IFC and raises REN if system control on.
// RULE12: clr after control passed away and not regained flags not_in_charge_error.
// RULE13: message bytes go on the bus exactly as received.
// RULE14: optional count follows a number sign, 1 to 4294967295, terminators excluded.
// RULE15: without count the first CR or LF ends the message string.
// RULE16: host ends the cmd line with LF or CR LF, never CR alone.
// RULE17: after a lone CR a leading LF message byte is discarded.
// RULE18: standby controller in charge takes control and asserts ATN before sending.
// RULE19: sending stops on done, not in charge, timeout, no listener, serial error.
// RULE20: the count of bytes really sent is recorded.
// RULE21: after an early stop the rest of the message is read and dropped.
// RULE22: keywords are accepted in upper or lower case.
`timescale 1ns/10ps
module bus_controller_command_ops #(
	parameter int IFC_PULSE_CYCLES = bus_ctl_pkg::IFC_CYCLES,
	parameter logic [31:0] IO_TIMEOUT_DEFAULT = 32'(bus_ctl_pkg::IO_TIMEOUT_CYCLES)
) (
	input wire logic clk,
	input wire logic sys_rst,
	input wire logic wb_cyc,
	input wire logic wb_stb,
	input wire logic wb_we,
	input wire logic [7:0] wb_adr,
	input wire logic [3:0] wb_sel,
	input wire logic [31:0] wb_dat_w,
	output logic [31:0] wb_dat_r,
	output logic wb_ack,
	input wire logic [7:0] rx_data,
	input wire logic rx_valid,
	output logic rx_ready,
	input wire logic rx_error,
	output logic [7:0] tx_data,
	output logic tx_valid,
	input wire logic tx_ready,
	output logic [7:0] bus_byte,
	output logic bus_byte_valid,
	input wire logic bus_byte_done,
	input wire logic no_listener,
	input wire logic handshake_busy,
	input wire logic control_passed,
	input wire logic reinit,
	output logic ifc,
	output logic ren,
	output logic atn
);
	typedef enum logic [3:0] {S_KEY, S_ARG, S_CNT, S_MSG, S_IFC, S_SEND, S_SYNC, S_REPLY,
		S_SKIP} pstate_t;

	typedef struct packed {
		pstate_t st;
		pstate_t ret;
		bus_ctl_pkg::kw_t kw;
		bus_ctl_pkg::ctl_state_t ctl;
		logic cic;
		logic passed;
		logic ifc;
		logic ren;
		logic [39:0] key;
		logic [2:0] key_len;
		logic got_digit;
		logic in_sad;
		logic line_end;
		logic aborted;
		logic counted;
		logic cmd_cr;
		logic [4:0] tmp_pad;
		logic [31:0] remaining;
		logic [4:0] pad;
		logic [4:0] sad;
		logic sad_en;
		logic [7:0] bus_byte;
		logic [1:0] clr_step;
		logic [4:0] clr_pad;
		logic [4:0] clr_sad;
		logic clr_has_sad;
		logic [31:0] timer;
		logic [31:0] sent;
		logic sysctl;
		logic spign;
		logic [31:0] tmo;
		logic e_cic;
		logic e_abo;
		logic e_nol;
		logic e_ser;
		logic ack;
		logic [31:0] dat;
	} state_t;

	state_t s;
	state_t n;
	logic dec_clear;
	logic dec_digit_valid;
	logic [31:0] dec_val;
	logic reply_start;
	logic [4:0] reply_a;
	logic reply_has_b;
	logic [4:0] reply_b;
	logic reply_busy;
	logic take;
	logic [7:0] ch;
	logic is_eol;
	logic is_digit;

	decimal_accumulator #(.WIDTH(32)) u_dec (
		.clk(clk),
		.sys_rst(sys_rst),
		.clear(dec_clear),
		.digit_valid(dec_digit_valid),
		.digit(rx_data[3:0]),
		.value(dec_val)
	);

	reply_formatter u_reply (
		.clk(clk),
		.sys_rst(sys_rst),
		.start(reply_start),
		.val_a(reply_a),
		.has_b(reply_has_b),
		.val_b(reply_b),
		.tx_data(tx_data),
		.tx_valid(tx_valid),
		.tx_ready(tx_ready),
		.busy(reply_busy)
	);

	// serial bytes are taken only in parsing states
	assign rx_ready = (s.st == S_KEY) || (s.st == S_ARG) || (s.st == S_CNT) ||
		(s.st == S_MSG) || (s.st == S_SKIP);
	assign take = rx_valid && rx_ready;
	assign ch = bus_ctl_pkg::to_lower(rx_data); // see RULE22
	assign is_eol = (rx_data == bus_ctl_pkg::CH_CR) || (rx_data == bus_ctl_pkg::CH_LF);
	assign is_digit = (rx_data >= bus_ctl_pkg::CH_ZERO) && (rx_data <= bus_ctl_pkg::CH_NINE);

	// register file, command parser and bus sequencer
	always_comb
	begin
		bus_ctl_pkg::chk_t chk;
		logic has_field;
		logic [4:0] cur_pad;
		logic last;
		logic stop;
		n = s;
		chk = bus_ctl_pkg::CHK_OK;
		has_field = s.got_digit || s.in_sad;
		cur_pad = s.in_sad ? s.tmp_pad : dec_val[4:0];
		last = 1'b0;
		stop = 1'b0;
		dec_clear = 1'b0;
		dec_digit_valid = 1'b0;
		reply_start = 1'b0;
		reply_a = '0;
		reply_has_b = 1'b0;
		reply_b = '0;

		// wishbone slave: one-cycle ack, writes land on the ack edge, W1C flags first
		n.ack = wb_cyc && wb_stb && !s.ack;
		if (wb_cyc && wb_stb && s.ack && wb_we)
		begin
			case (wb_adr)
				bus_ctl_pkg::REG_CTRL:
				begin
					if (wb_sel[0])
					begin
						n.sysctl = wb_dat_w[bus_ctl_pkg::CTRL_SYSCTL_BIT];
						n.spign = wb_dat_w[bus_ctl_pkg::CTRL_SPIGN_BIT];
					end
				end
				bus_ctl_pkg::REG_STATUS:
				begin
					if (wb_sel[0])
					begin
						n.e_cic = s.e_cic && !wb_dat_w[bus_ctl_pkg::STAT_NOT_IN_CHARGE_BIT];
						n.e_abo = s.e_abo && !wb_dat_w[bus_ctl_pkg::STAT_IO_TIMEOUT_BIT];
						n.e_nol = s.e_nol && !wb_dat_w[bus_ctl_pkg::STAT_NO_LISTENER_BIT];
						n.e_ser = s.e_ser && !wb_dat_w[bus_ctl_pkg::STAT_SERIAL_BIT];
					end
				end
				bus_ctl_pkg::REG_TMO: n.tmo = bus_ctl_pkg::wb_merge(s.tmo, wb_dat_w, wb_sel);
				default: ;
			endcase
		end
		n.dat = '0;
		case (wb_adr)
			bus_ctl_pkg::REG_CTRL:
			begin
				n.dat[bus_ctl_pkg::CTRL_SYSCTL_BIT] = s.sysctl;
				n.dat[bus_ctl_pkg::CTRL_SPIGN_BIT] = s.spign;
			end
			bus_ctl_pkg::REG_STATUS:
			begin
				n.dat[bus_ctl_pkg::STAT_CTL_LSB +: 2] = s.ctl;
				n.dat[bus_ctl_pkg::STAT_CIC_BIT] = s.cic;
				n.dat[bus_ctl_pkg::STAT_NOT_IN_CHARGE_BIT] = s.e_cic;
				n.dat[bus_ctl_pkg::STAT_IO_TIMEOUT_BIT] = s.e_abo;
				n.dat[bus_ctl_pkg::STAT_NO_LISTENER_BIT] = s.e_nol;
				n.dat[bus_ctl_pkg::STAT_SERIAL_BIT] = s.e_ser;
			end
			bus_ctl_pkg::REG_SENT: n.dat = s.sent;
			bus_ctl_pkg::REG_ADDR:
			begin
				n.dat[bus_ctl_pkg::ADDR_PAD_LSB +: 5] = s.pad;
				n.dat[bus_ctl_pkg::ADDR_SAD_LSB +: 5] = s.sad;
				n.dat[bus_ctl_pkg::ADDR_SAD_EN_BIT] = s.sad_en;
			end
			bus_ctl_pkg::REG_TMO: n.dat = s.tmo;
			default: ;
		endcase

		// bus and serial side events
		if (control_passed)
		begin
			n.cic = 1'b0;
			n.passed = 1'b1;
			n.ctl = bus_ctl_pkg::CTL_IDLE;
		end
		if (reinit)
		begin
			n.pad = bus_ctl_pkg::PAD_RESET; // see RULE8
			n.sad = '0;
			n.sad_en = bus_ctl_pkg::SAD_EN_RESET;
		end
		if (rx_error && !s.spign)
		begin
			n.e_ser = 1'b1;
			if (s.kw == bus_ctl_pkg::K_CMD)
				n.aborted = 1'b1; // see RULE19
		end

		case (s.st)
			S_KEY:
			begin
				if (take)
				begin
					if (is_eol || ch == bus_ctl_pkg::CH_SP || ch == bus_ctl_pkg::CH_HASH)
					begin
						if (s.key_len != 3'h0)
						begin
							n.kw = bus_ctl_pkg::decode_kw(s.key, s.key_len);
							n.key = '0;
							n.key_len = '0;
							dec_clear = 1'b1;
							n.got_digit = 1'b0;
							n.in_sad = 1'b0;
							n.line_end = is_eol;
							n.st = is_eol ? S_KEY : S_SKIP;
							case (n.kw)
								bus_ctl_pkg::K_CAC:
								begin
									n.st = is_eol ? S_REPLY : S_ARG;
									reply_start = is_eol; // see RULE2
									reply_a = (s.ctl == bus_ctl_pkg::CTL_ACTIVE) ? 5'd1 : 5'd0;
								end
								bus_ctl_pkg::K_CADDR:
								begin
									n.st = is_eol ? S_REPLY : S_ARG;
									reply_start = is_eol; // see RULE7
									reply_a = s.pad;
									reply_has_b = s.sad_en;
									reply_b = s.sad;
								end
								bus_ctl_pkg::K_CLR, bus_ctl_pkg::K_CMD:
								begin
									chk = bus_ctl_pkg::ctl_check(s.cic, s.passed, s.sysctl);
									if (n.kw == bus_ctl_pkg::K_CLR)
									begin
										n.bus_byte = bus_ctl_pkg::MSG_DCL; // see RULE10
										n.clr_step = 2'd0;
										n.ret = is_eol ? S_SEND : S_ARG;
									end
									else
									begin
										n.sent = '0;
										n.aborted = 1'b0;
										n.counted = 1'b0;
										n.cmd_cr = (rx_data == bus_ctl_pkg::CH_CR);
										n.ret = is_eol ? S_MSG : S_CNT;
									end
									n.st = n.ret;
									if (chk == bus_ctl_pkg::CHK_IFC)
									begin
										n.st = S_IFC; // see RULE11
										n.timer = '0;
										n.ifc = 1'b1;
										n.ren = 1'b1;
									end
									else if (chk == bus_ctl_pkg::CHK_ERR)
									begin
										n.e_cic = 1'b1; // see RULE12
										n.aborted = 1'b1;
										if (n.kw == bus_ctl_pkg::K_CLR)
											n.st = is_eol ? S_KEY : S_SKIP;
									end
									else
										n.ctl = bus_ctl_pkg::CTL_ACTIVE; // see RULE18
								end
								default: ;
							endcase
						end
					end
					else if (s.key_len <= 3'(bus_ctl_pkg::KEY_MAX))
					begin
						n.key = {s.key[31:0], ch}; // see RULE22
						n.key_len = 3'(s.key_len + 3'h1);
					end
				end
			end
			S_ARG:
			begin
				if (take)
				begin
					if (is_digit)
					begin
						dec_digit_valid = 1'b1; // see RULE5
						n.got_digit = 1'b1;
					end
					else if (rx_data == bus_ctl_pkg::CH_PLUS)
					begin
						n.tmp_pad = dec_val[4:0]; // see RULE5
						n.in_sad = 1'b1;
						n.got_digit = 1'b0;
						dec_clear = 1'b1;
					end
					else
					begin
						n.line_end = is_eol;
						dec_clear = 1'b1;
						n.got_digit = 1'b0;
						n.in_sad = 1'b0;
						if (is_eol)
							n.st = S_KEY;
						if (s.kw == bus_ctl_pkg::K_CAC && has_field)
						begin
							if (!s.cic)
								n.e_cic = 1'b1; // see RULE3
							else if (dec_val == 32'h0)
								n.ctl = bus_ctl_pkg::CTL_ACTIVE; // see RULE1
							else
								n.st = S_SYNC;
						end
						else if (s.kw == bus_ctl_pkg::K_CADDR && has_field)
						begin
							n.pad = cur_pad;
							n.sad_en = s.in_sad; // see RULE6
							n.sad = s.in_sad ? dec_val[4:0] : 5'h00;
						end
						else if (s.kw == bus_ctl_pkg::K_CLR && has_field)
						begin
							n.clr_pad = cur_pad; // see RULE10
							n.clr_sad = dec_val[4:0];
							n.clr_has_sad = s.in_sad;
							n.bus_byte = bus_ctl_pkg::MSG_UNL;
							n.clr_step = 2'd1;
							n.timer = '0;
							n.st = S_SEND;
						end
					end
				end
			end
			S_CNT:
			begin
				if (take)
				begin
					if (is_digit)
					begin
						dec_digit_valid = 1'b1; // see RULE14
						n.got_digit = 1'b1;
					end
					else if (is_eol)
					begin
						n.counted = s.got_digit && (dec_val != 32'h0);
						n.remaining = dec_val;
						n.cmd_cr = (rx_data == bus_ctl_pkg::CH_CR);
						n.st = S_MSG;
					end
				end
			end
			S_MSG:
			begin
				if (take)
				begin
					n.cmd_cr = 1'b0;
					if (s.cmd_cr && rx_data == bus_ctl_pkg::CH_LF)
						n.cmd_cr = 1'b0; // see RULE17
					else if (!s.counted && is_eol)
						n.st = S_KEY; // see RULE15
					else
					begin
						if (s.counted)
						begin
							n.remaining = s.remaining - 32'h1;
							last = (s.remaining == 32'h1);
						end
						if (!s.aborted && !s.cic)
						begin
							n.e_cic = 1'b1; // see RULE19
							n.aborted = 1'b1;
						end
						if (!s.aborted && s.cic)
						begin
							n.bus_byte = rx_data; // see RULE13
							n.timer = '0;
							n.st = S_SEND;
						end
						else if (last)
							n.st = S_KEY; // see RULE21
					end
				end
			end
			S_SEND:
			begin
				n.timer = s.timer + 32'h1;
				if (bus_byte_done)
				begin
					if (s.kw == bus_ctl_pkg::K_CMD)
						n.sent = s.sent + 32'h1; // see RULE20
					stop = 1'b1;
				end
				else if (no_listener)
				begin
					n.e_nol = 1'b1;
					n.aborted = 1'b1;
					n.clr_step = 2'd0;
					stop = 1'b1;
				end
				else if (s.timer >= s.tmo)
				begin
					n.e_abo = 1'b1; // see RULE19
					n.aborted = 1'b1;
					n.clr_step = 2'd0;
					stop = 1'b1;
				end
				if (stop)
				begin
					n.timer = '0;
					if (s.kw == bus_ctl_pkg::K_CMD)
						n.st = (s.counted && s.remaining == 32'h0) ? S_KEY : S_MSG;
					else if (n.clr_step == 2'd1)
					begin
						n.bus_byte = bus_ctl_pkg::MSG_LAD | {3'h0, s.clr_pad};
						n.clr_step = s.clr_has_sad ? 2'd2 : 2'd3;
					end
					else if (n.clr_step == 2'd2)
					begin
						n.bus_byte = bus_ctl_pkg::MSG_SAD | {3'h0, s.clr_sad};
						n.clr_step = 2'd3;
					end
					else if (n.clr_step == 2'd3)
					begin
						n.bus_byte = bus_ctl_pkg::MSG_SDC;
						n.clr_step = 2'd0;
					end
					else if (n.aborted)
						n.st = s.line_end ? S_KEY : S_SKIP;
					else
						n.st = s.line_end ? S_KEY : S_ARG;
				end
			end
			S_IFC:
			begin
				n.timer = s.timer + 32'h1;
				if (s.timer >= 32'(IFC_PULSE_CYCLES - 1))
				begin
					n.ifc = 1'b0; // see RULE11
					n.cic = 1'b1;
					n.passed = 1'b0;
					n.ctl = bus_ctl_pkg::CTL_ACTIVE;
					n.timer = '0;
					n.st = s.ret;
				end
			end
			S_SYNC:
			begin
				if (!handshake_busy)
				begin
					n.ctl = bus_ctl_pkg::CTL_ACTIVE; // see RULE1
					n.st = s.line_end ? S_KEY : S_SKIP;
				end
			end
			S_REPLY:
			begin
				if (!reply_busy && !reply_start)
					n.st = S_KEY;
			end
			S_SKIP:
			begin
				if (take && is_eol)
					n.st = S_KEY;
			end
			default: n.st = S_KEY;
		endcase
	end

	// state register; reset gives idle controller and address 0 without secondary
	always_ff @(posedge clk)
	begin
		if (sys_rst)
		begin
			s <= '0; // see RULE4
			s.pad <= bus_ctl_pkg::PAD_RESET; // see RULE9
			s.sad_en <= bus_ctl_pkg::SAD_EN_RESET;
			s.sysctl <= bus_ctl_pkg::CTRL_SYSCTL_RESET;
			s.spign <= bus_ctl_pkg::CTRL_SPIGN_RESET;
			s.tmo <= IO_TIMEOUT_DEFAULT;
		end
		else
			s <= n;
	end

	// outputs
	assign wb_dat_r = s.dat;
	assign wb_ack = s.ack;
	assign bus_byte = s.bus_byte;
	assign bus_byte_valid = (s.st == S_SEND);
	assign ifc = s.ifc;
	assign ren = s.ren;
	assign atn = (s.ctl == bus_ctl_pkg::CTL_ACTIVE); // see RULE18
endmodule : bus_controller_command_ops

// [bench/bus_ctl_chk.sv]
/* port assertions for the command interpreter
   bound to every bus_controller_command_ops; one clock domain */
`timescale 1ns/10ps
module bus_ctl_chk #(
	parameter int IFC_PULSE_CYCLES = 8
) (
	input wire logic clk,
	input wire logic sys_rst,
	input wire logic wb_cyc,
	input wire logic wb_stb,
	input wire logic wb_ack,
	input wire logic rx_ready,
	input wire logic [7:0] tx_data,
	input wire logic tx_valid,
	input wire logic tx_ready,
	input wire logic [7:0] bus_byte,
	input wire logic bus_byte_valid,
	input wire logic bus_byte_done,
	input wire logic no_listener,
	input wire logic ifc,
	input wire logic ren,
	input wire logic atn
);
	localparam int IFC_LO = IFC_PULSE_CYCLES - 1;
	localparam int IFC_HI = IFC_PULSE_CYCLES + 1;
	default clocking @(posedge clk); endclocking
	default disable iff (sys_rst);
	// register bus answer timing
	a_ack_next: assert property (wb_cyc && wb_stb && !wb_ack |=> wb_ack)
		else $error("ack missing");
	a_ack_single: assert property (wb_ack |=> !wb_ack)
		else $error("ack too long");
	// quiet after reset
	a_reset_idle: assert property ($fell(sys_rst) |-> !ifc && !ren && !atn)
		else $error("not idle after reset");
	// interface clear pulse and remote enable
	a_ifc_len: assert property ($rose(ifc) |-> ##[IFC_LO:IFC_HI] !ifc)
		else $error("ifc pulse length");
	a_ren_after: assert property ($fell(ifc) |-> ##[0:2] ren)
		else $error("ren not raised");
	// no serial intake while busy on the bus
	a_rx_hold: assert property (ifc || bus_byte_valid |-> !rx_ready)
		else $error("rx taken while busy");
	// message and reply bytes stand until answered
	a_byte_stable: assert property (bus_byte_valid && !bus_byte_done && !no_listener
		##1 bus_byte_valid |-> $stable(bus_byte))
		else $error("bus byte changed");
	a_byte_end: assert property (bus_byte_valid && bus_byte_done |=>
		!bus_byte_valid || $changed(bus_byte))
		else $error("valid after done");
	a_tx_stand: assert property (tx_valid && !tx_ready |=> tx_valid && $stable(tx_data))
		else $error("reply byte dropped");
	c_ifc: cover property ($rose(ifc));
	c_byte: cover property (bus_byte_valid && bus_byte_done);
	c_nolisten: cover property (no_listener);
endmodule : bus_ctl_chk

bind bus_controller_command_ops bus_ctl_chk #(.IFC_PULSE_CYCLES(IFC_PULSE_CYCLES)) chk_i (
	.clk, .sys_rst, .wb_cyc, .wb_stb, .wb_ack, .rx_ready, .tx_data, .tx_valid, .tx_ready,
	.bus_byte, .bus_byte_valid, .bus_byte_done, .no_listener, .ifc, .ren, .atn);

// [bench/bus_engine_model.sv]
/* behavioural bus handshake engine facing the interpreter
   answers each byte lat+1 cycles after it is offered, or refuses with no listener when nl */
`timescale 1ns/10ps
module bus_engine_model (
	input wire logic clk,
	input wire logic sys_rst,
	input wire logic [7:0] bus_byte,
	input wire logic bus_byte_valid,
	output logic bus_byte_done,
	output logic no_listener,
	output logic handshake_busy,
	input wire logic nl,
	input wire logic [3:0] lat
);
	logic [3:0] cnt;
	logic [31:0] log = 32'h0;
	// handshake each offered byte and log what went out
	always @(posedge clk)
	begin
		bus_byte_done <= 1'h0;
		no_listener <= 1'h0;
		if (sys_rst)
		begin
			cnt <= 4'h0;
			handshake_busy <= 1'h0;
		end
		else if (bus_byte_valid && !bus_byte_done && !no_listener)
		begin
			handshake_busy <= 1'h1;
			cnt <= cnt + 4'h1;
			if (cnt >= lat)
			begin
				cnt <= 4'h0;
				handshake_busy <= 1'h0;
				if (nl)
					no_listener <= 1'h1;
				else
				begin
					bus_byte_done <= 1'h1;
					log <= {log[23:0], bus_byte};
				end
			end
		end
	end
endmodule : bus_engine_model

// [bench/testbench.sv]
/* self-checking bench for the command interpreter
   expects the package, design, engine model and checker compiled first */
`timescale 1ns/10ps
module testbench;
	logic clk = 1'h0, sys_rst = 1'h1, wb_cyc = 1'h0, wb_stb = 1'h0, wb_we = 1'h0;
	logic [7:0] wb_adr = 8'h00, rx_data = 8'h00, bus_byte, tx_data;
	logic [31:0] wb_dat_w = 32'h0, wb_dat_r, txl = 32'h0;
	logic rx_valid = 1'h0, rx_ready, tx_valid, bus_byte_valid, bus_byte_done, no_listener;
	logic handshake_busy, control_passed = 1'h0, reinit = 1'h0, ifc, ren, atn, wb_ack, nl = 1'h0;
	logic [3:0] lat = 4'h0;
	int failures = 0, num_checks = 0;
	initial
	begin
		forever #5 clk = ~clk;
	end
	bus_controller_command_ops #(.IFC_PULSE_CYCLES(8), .IO_TIMEOUT_DEFAULT(32'hC8)) DUT (
		.clk, .sys_rst, .wb_cyc, .wb_stb, .wb_we, .wb_adr, .wb_sel(4'hF), .wb_dat_w, .wb_dat_r,
		.wb_ack, .rx_data, .rx_valid, .rx_ready, .rx_error(1'h0), .tx_data, .tx_valid,
		.tx_ready(1'h1), .bus_byte, .bus_byte_valid, .bus_byte_done, .no_listener,
		.handshake_busy, .control_passed, .reinit, .ifc, .ren, .atn);
	bus_engine_model eng (.clk, .sys_rst, .bus_byte, .bus_byte_valid, .bus_byte_done,
		.no_listener, .handshake_busy, .nl, .lat);
	// log reply bytes
	always @(posedge clk)
		if (tx_valid === 1'h1)
			txl <= {txl[23:0], tx_data};
	task conclude;
		if (failures == 0 && num_checks > 0)
			$display("NO MISMATCHES");
		else
			$display("MISMATCHES SEEN");
		$finish;
	endtask : conclude
	task chk(input string n, input logic [31:0] s, input logic [31:0] e);
		num_checks++;
		if (s !== e)
		begin
			failures++;
			$display("BAD %s expected %h seen %h", n, e, s);
		end
	endtask : chk
	// one classic wishbone cycle
	task wb(input logic we, input logic [7:0] a, input logic [31:0] d, output logic [31:0] q);
		@(posedge clk);
		wb_cyc <= 1'h1;
		wb_stb <= 1'h1;
		wb_we <= we;
		wb_adr <= a;
		wb_dat_w <= d;
		do @(posedge clk); while (wb_ack !== 1'h1);
		q = wb_dat_r;
		wb_cyc <= 1'h0;
		wb_stb <= 1'h0;
	endtask : wb
	task rc(input string n, input logic [7:0] a, input logic [31:0] e);
		logic [31:0] q;
		wb(1'h0, a, 32'h0, q);
		chk(n, q, e);
	endtask : rc
	// host line in, then wait for the interpreter to go quiet
	task send(input string s);
		@(posedge clk);
		rx_valid <= 1'h1;
		for (int i = 0; i < s.len(); i++)
		begin
			rx_data <= s[i];
			do @(posedge clk); while (rx_ready !== 1'h1);
		end
		rx_valid <= 1'h0;
		repeat (3) @(posedge clk);
		while (rx_ready !== 1'h1 || bus_byte_valid !== 1'h0)
			@(posedge clk);
	endtask : send
	initial
	begin
		repeat (20000) @(posedge clk);
		failures++;
		conclude;
	end
	initial
	begin
		logic [31:0] q;
		repeat (5) @(posedge clk);
		sys_rst <= 1'h0;
		rc("status", bus_ctl_pkg::REG_STATUS, 32'h0);
		rc("addr", bus_ctl_pkg::REG_ADDR, 32'h0);
		send("CAC\r");
		chk("cac reply", txl, 32'h00300D0A);
		send("cac 0\n");
		rc("status", bus_ctl_pkg::REG_STATUS, 32'h10);
		wb(1'h1, bus_ctl_pkg::REG_STATUS, 32'h10, q);
		send("caddr 5+9\n");
		rc("addr", bus_ctl_pkg::REG_ADDR, 32'h8905);
		send("caddr 7\ncaddr\n");
		rc("addr", bus_ctl_pkg::REG_ADDR, 32'h7);
		chk("caddr reply", txl, 32'h0A370D0A);
		reinit <= 1'h1;
		@(posedge clk);
		reinit <= 1'h0;
		rc("addr", bus_ctl_pkg::REG_ADDR, 32'h0);
		send("clr\n");
		chk("dcl", eng.log, 32'h14);
		rc("status", bus_ctl_pkg::REG_STATUS, 32'h6);
		chk("ren atn", {30'h0, ren, atn}, 32'h3);
		send("clr 3+4\n");
		chk("sdc", eng.log, 32'h3F236404);
		lat <= 4'h5;
		send("cmd\n_?\r");
		chk("cmd", eng.log, 32'h64045F3F);
		rc("sent", bus_ctl_pkg::REG_SENT, 32'h2);
		send("cmd #2\r\n\r?");
		chk("counted", eng.log, 32'h5F3F0D3F);
		nl <= 1'h1;
		send("cmd\nAB\r");
		nl <= 1'h0;
		rc("status", bus_ctl_pkg::REG_STATUS, 32'h46);
		rc("sent", bus_ctl_pkg::REG_SENT, 32'h0);
		send("cac 1\ncac\n");
		chk("resync", txl, 32'h0A310D0A);
		control_passed <= 1'h1;
		@(posedge clk);
		control_passed <= 1'h0;
		send("clr\n");
		wb(1'h0, bus_ctl_pkg::REG_STATUS, 32'h0, q);
		chk("passed", {31'h0, q[4]}, 32'h1);
		conclude;
	end
endmodule : testbench
